// ---- hsdp_pkg.sv ----
package hsdp_pkg;
  // datagram framing
  localparam int DG_BITS = 32; // bits in every datagram
  localparam int DG_SPACE_BIT = 31; // space select position
  localparam int DG_ADDR_LO = 25; // lowest address bit
  localparam int DG_ADDR_W = 6; // address width
  localparam int DG_RNW_BIT = 24; // read / not write position
  localparam int DG_DATA_W = 24; // data field width
  localparam int DG_STAT_W = 8; // status byte width in the reply
  localparam int DG_CNT_W = 6; // bit counter width, saturates
  localparam int SYNC_STAGES = 2; // flops before any logic looks
  // host timing minimums in system clock periods, kept by the host
  localparam int SCK_MIN_PHASE_CYC = 3; // low or high phase
  localparam int SEL_MIN_GAP_CYC = 3; // select setup and hold
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00; // internal interrupt level
  localparam logic [7:0] REG_STATUS = 8'h04; // status byte of replies
  localparam logic [7:0] REG_RDATA = 8'h08; // read data of replies
  localparam logic [7:0] REG_REQ = 8'h0C; // last request, read only
  localparam logic [7:0] REG_EVT = 8'h10; // sticky events, write 1 clears
  localparam logic [7:0] REG_WMASK = 8'h14; // used data bits of writes
  // field positions
  localparam int CTRL_INT_BIT = 0; // active-high interrupt level
  localparam int EVT_REQ_BIT = 0; // good request received
  localparam int EVT_ERR_BIT = 1; // frame with wrong bit count
  localparam int EVT_BUSY_BIT = 2; // frame in progress, read only
  // reset values
  localparam logic CTRL_INT_RST = 1'b0; // no interrupt pending
  localparam logic [7:0] STATUS_RST = 8'h00; // status byte
  localparam logic [23:0] RDATA_RST = 24'h000000; // read data
  localparam logic [23:0] WMASK_RST = 24'hFFFFFF; // all data bits used
  localparam logic [1:0] EVT_RST = 2'h0; // no events
  // types
  typedef enum logic {LNK_IDLE, LNK_FRAME} hsdp_state_t; // link states
  typedef struct packed {
    logic cyc; // bus cycle
    logic stb; // strobe
    logic we; // write enable
    logic [7:0] adr; // byte address
    logic [3:0] sel; // byte lanes
    logic [31:0] dat; // write data
  } hsdp_wb_req_t;
  typedef struct packed {
    logic valid; // one-cycle pulse per request
    logic space; // 1 selects ram, 0 registers
    logic [DG_ADDR_W-1:0] addr; // address within space
    logic rnw; // 1 read, 0 write
    logic [DG_DATA_W-1:0] data; // write data, zero on reads
  } hsdp_req_t;
endpackage : hsdp_pkg

// ---- hsdp_sync.sv ----
`timescale 1ns/1ps
module hsdp_sync #(
  parameter int WIDTH = 3 // number of pins
) (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // async reset, high
  input wire logic [WIDTH-1:0] pin_in, // asynchronous pins
  output logic [WIDTH-1:0] lvl_out, // synchronized level
  output logic [WIDTH-1:0] rise_out, // one-cycle rise pulse
  output logic [WIDTH-1:0] fall_out // one-cycle fall pulse
);
  import hsdp_pkg::*;
  logic [WIDTH-1:0] s1_q, s2_q, s3_q; // chain stages
  logic [WIDTH-1:0] s1_d, s2_d, s3_d; // next values

  ////////////////////////////////////////////////////////////////////
  // two flops per pin, third only for edge finding
  always_comb begin
    s1_d = pin_in;
    s2_d = s1_q; // s1 feeds nothing but s2
    s3_d = s2_q;
  end

  // idle select and clock pins sit high, so reset to high avoids a false edge on them
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // edges from settled stages only
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_edge
      assign lvl_out[gi] = s2_q[gi];
      assign rise_out[gi] = s2_q[gi] & ~s3_q[gi];
      assign fall_out[gi] = ~s2_q[gi] & s3_q[gi];
    end
  endgenerate

  // watches settled stages only, the first flop stays private to the chain
  edge_from_sync_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (rise_out != '0) |-> ((lvl_out & rise_out) == rise_out)
      && (($past(lvl_out) & rise_out) == '0))
    else $error("edge not taken from synchronized stages");
endmodule : hsdp_sync

// ---- hsdp_port.sv ----
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
// Functional notes
// - one select assertion frames one 32-bit datagram
// - select, clock, data synchronized before use
// - select high puts interrupt status out
// - input bit sampled on clock rise
// - no upper limit on clock period
// - both directions shift most significant first
// - serial output always driven, never floated
// - reply bit valid 2.5 to 3.5 cycles
// - interrupt status timing around select edges
// - reply is status byte plus 24 data
// - read_not_write one reads, zero writes
// - bit 31 selects registers or ram
// - data bits ignored on read requests
// - only used low data bits are kept
// - shift register copied on select rise
// - read_not_write taken from bit 24
module hsdp_port (
  input wire logic clk_in, // system clock, 100 MHz
  input wire logic rst_in, // async reset, high
  input wire logic host_select_n_in, // frame select pin, low active
  input wire logic host_serial_clock_in, // serial clock pin
  input wire logic host_serial_in_in, // serial data pin
  output logic host_serial_out_out, // reply data or interrupt status
  output hsdp_pkg::hsdp_req_t req_out, // decoded request to the core
  input hsdp_pkg::hsdp_wb_req_t wb_in, // wishbone request
  output logic wb_ack_out, // wishbone ack
  output logic [31:0] wb_dat_out // wishbone read data
);
  import hsdp_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // pin synchronizers
  logic [2:0] lvl, rise, fall; // sel, sck, sdi
  logic sel_lvl, sel_rise, sel_fall; // select views
  logic sck_rise, sck_fall; // clock edges
  logic sdi_lvl; // data level, same delay as clock

  hsdp_sync #(.WIDTH(3)) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in({host_select_n_in, host_serial_clock_in, host_serial_in_in}),
    .lvl_out(lvl),
    .rise_out(rise),
    .fall_out(fall)
  );

  assign sel_lvl = lvl[2];
  assign sel_rise = rise[2];
  assign sel_fall = fall[2];
  assign sck_rise = rise[1];
  assign sck_fall = fall[1];
  assign sdi_lvl = lvl[0];

  ////////////////////////////////////////////////////////////////////
  // register state declarations
  logic ack_q, ack_d; // bus ack
  logic [31:0] dat_q, dat_d; // bus read data
  logic int_q, int_d; // internal interrupt, active high
  logic [DG_STAT_W-1:0] status_q, status_d; // reply status byte
  logic [DG_DATA_W-1:0] rdata_q, rdata_d; // reply read data
  logic [DG_DATA_W-1:0] wmask_q, wmask_d; // used write data bits
  logic [1:0] evt_q, evt_d; // sticky events
  logic int_n; // interrupt_status_n, low when pending

  ////////////////////////////////////////////////////////////////////
  // link state declarations
  hsdp_state_t state_q, state_d; // frame tracking
  logic [DG_CNT_W-1:0] cnt_q, cnt_d; // bits shifted in
  logic [DG_BITS-1:0] rx_q, rx_d; // request shift register
  logic [DG_BITS-1:0] tx_q, tx_d; // reply shift register
  logic sdo_q, sdo_d; // serial output flop
  hsdp_req_t req_q, req_d; // request buffer
  logic done_q, done_d; // good frame pulse
  logic bad_q, bad_d; // bad frame pulse

  assign int_n = ~int_q;

  ////////////////////////////////////////////////////////////////////
  // link next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    sdo_d = sdo_q; // holds, so any clock phase length is fine
    req_d = req_q;
    req_d.valid = 1'b0;
    done_d = 1'b0;
    bad_d = 1'b0;
    case (state_q)
      LNK_IDLE: begin
        sdo_d = int_n;
        if (sel_fall) begin
          // reply frozen at frame start so software edits cannot tear it
          state_d = LNK_FRAME;
          cnt_d = '0;
          tx_d = {status_q, rdata_q};
        end
      end
      LNK_FRAME: begin
        if (sel_rise) begin
          state_d = LNK_IDLE;
          sdo_d = int_n;
          if (cnt_q == DG_CNT_W'(DG_BITS)) begin
            req_d.valid = 1'b1;
            req_d.space = rx_q[DG_SPACE_BIT];
            req_d.addr = rx_q[DG_ADDR_LO +: DG_ADDR_W];
            req_d.rnw = rx_q[DG_RNW_BIT];
            // reads carry no data; writes keep only the used bits
            if (rx_q[DG_RNW_BIT]) begin
              req_d.data = '0;
            end else begin
              req_d.data = rx_q[DG_DATA_W-1:0] & wmask_q;
            end
            done_d = 1'b1;
          end else begin
            bad_d = 1'b1; // short or long frame is dropped
          end
        end else begin
          if (sck_rise) begin
            rx_d = {rx_q[DG_BITS-2:0], sdi_lvl};
            // saturate so a long frame can never wrap back to 32
            if (cnt_q != '1) begin
              cnt_d = cnt_q + DG_CNT_W'(1);
            end
          end
          if (sck_fall) begin
            sdo_d = tx_q[DG_BITS-1];
            tx_d = {tx_q[DG_BITS-2:0], 1'b0};
          end
        end
      end
      default: begin
        state_d = LNK_IDLE;
      end
    endcase
  end

  // link registers; output stays driven through reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= LNK_IDLE;
      cnt_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      sdo_q <= 1'b1;
      req_q <= '0;
      done_q <= 1'b0;
      bad_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      sdo_q <= sdo_d;
      req_q <= req_d;
      done_q <= done_d;
      bad_q <= bad_d;
    end
  end

  assign host_serial_out_out = sdo_q;
  assign req_out = req_q;

  ////////////////////////////////////////////////////////////////////
  // wishbone slave
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  logic bus_hit; // request on the bus, in any cycle
  logic wr_en; // write takes effect this edge
  logic [31:0] wmrg; // merged write word
  logic [31:0] evt_clr; // write-one-clear pattern

  assign bus_hit = wb_in.cyc & wb_in.stb;
  assign wr_en = bus_hit & wb_in.we & ack_q;

  // one wait state: ack one edge after the request, write at the edge that ends the ack
  always_comb begin
    ack_d = bus_hit & ~ack_q;
    dat_d = '0; // unmapped reads return zero
    int_d = int_q;
    status_d = status_q;
    rdata_d = rdata_q;
    wmask_d = wmask_q;
    wmrg = '0;
    evt_clr = '0;
    if (wb_in.adr == REG_CTRL) begin
      dat_d = {31'h00000000, int_q};
      wmrg = merge({31'h00000000, int_q}, wb_in.dat, wb_in.sel);
      if (wr_en) begin
        int_d = wmrg[CTRL_INT_BIT];
      end
    end else if (wb_in.adr == REG_STATUS) begin
      dat_d = {24'h000000, status_q};
      wmrg = merge({24'h000000, status_q}, wb_in.dat, wb_in.sel);
      if (wr_en) begin
        status_d = wmrg[DG_STAT_W-1:0];
      end
    end else if (wb_in.adr == REG_RDATA) begin
      dat_d = {8'h00, rdata_q};
      wmrg = merge({8'h00, rdata_q}, wb_in.dat, wb_in.sel);
      if (wr_en) begin
        rdata_d = wmrg[DG_DATA_W-1:0];
      end
    end else if (wb_in.adr == REG_REQ) begin
      dat_d = {req_q.space, req_q.addr, req_q.rnw, req_q.data};
    end else if (wb_in.adr == REG_EVT) begin
      dat_d = {29'h00000000, state_q == LNK_FRAME, evt_q};
      if (wr_en) begin
        evt_clr = merge(32'h00000000, wb_in.dat, wb_in.sel);
      end
    end else if (wb_in.adr == REG_WMASK) begin
      dat_d = {8'h00, wmask_q};
      wmrg = merge({8'h00, wmask_q}, wb_in.dat, wb_in.sel);
      if (wr_en) begin
        wmask_d = wmrg[DG_DATA_W-1:0];
      end
    end
    if (!ack_d) begin
      dat_d = '0;
    end
    // a frame ending in the clearing cycle still leaves its flag set
    evt_d = (evt_q & ~evt_clr[1:0]) | {bad_q, done_q};
  end

  // bus and control registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      dat_q <= '0;
      int_q <= CTRL_INT_RST;
      status_q <= STATUS_RST;
      rdata_q <= RDATA_RST;
      wmask_q <= WMASK_RST;
      evt_q <= EVT_RST;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
      int_q <= int_d;
      status_q <= status_d;
      rdata_q <= rdata_d;
      wmask_q <= wmask_d;
      evt_q <= evt_d;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = dat_q;

  ////////////////////////////////////////////////////////////////////
  // checks
  idle_int_out_a: assert property (@(posedge clk_in) disable iff (rst_in)
    sel_lvl |=> sdo_q == $past(int_n))
    else $error("serial output not showing interrupt while deselected");
  reply_bit_out_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == LNK_FRAME && sck_fall && !sel_rise)
    |=> sdo_q == $past(tx_q[DG_BITS-1]))
    else $error("reply bit not presented after clock fall");
  shift_in_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == LNK_FRAME && sck_rise && !sel_rise)
    |=> rx_q == {$past(rx_q[DG_BITS-2:0]), $past(sdi_lvl)})
    else $error("input bit not shifted on clock rise");
  reply_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == LNK_IDLE && sel_fall)
    |=> tx_q == {$past(status_q), $past(rdata_q)})
    else $error("reply not loaded with status and read data");
  frame_count_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == LNK_FRAME && sel_rise)
    |=> (req_q.valid == ($past(cnt_q) == DG_CNT_W'(DG_BITS)))
        && (bad_q == !req_q.valid))
    else $error("frame acceptance does not match bit count");
  req_fields_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == LNK_FRAME && sel_rise && cnt_q == DG_CNT_W'(DG_BITS))
    |=> req_q.space == $past(rx_q[DG_SPACE_BIT])
        && req_q.addr == $past(rx_q[DG_ADDR_LO +: DG_ADDR_W]))
    else $error("space or address decoded wrongly");
  req_rnw_a: assert property (@(posedge clk_in) disable iff (rst_in)
    req_q.valid |-> req_q.rnw == $past(rx_q[DG_RNW_BIT], 1))
    else $error("read flag not from bit 24");
  req_data_a: assert property (@(posedge clk_in) disable iff (rst_in)
    req_q.valid |-> req_q.data == (req_q.rnw ? '0
      : $past(rx_q[DG_DATA_W-1:0] & wmask_q)))
    else $error("request data not masked or not zeroed on read");
  int_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == LNK_IDLE && sel_fall) ##1 (!sck_fall && !sel_rise)
    |=> sdo_q == $past(sdo_q))
    else $error("output moved before first clock fall");
endmodule : hsdp_port

// ---- hsdp_host_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// host side of the serial link, paced by the system clock
module hsdp_host_model (
  input wire logic clk_in, // system clock, paces every pin change
  input wire logic miso_in, // reply line from the port
  output logic sel_n_out, // frame select, low active
  output logic sck_out, // serial clock, idles high
  output logic mosi_out // request data line
);
  // idle levels from time zero
  initial begin
    sel_n_out = 1'b1; // select idles high
    sck_out = 1'b1; // clock idles high
    mosi_out = 1'b0; // data line starts low
  end
  ////////////////////////////////////////////////////////////////
  // one frame of nb bits, ph system cycles in each clock phase
  // sampling the reply four edges after the fall is stricter than at the rise
  task automatic xfer(input int nb, input logic [31:0] tx, input int ph,
                      output logic [31:0] rx);
    rx = '0;
    sel_n_out <= 1'b0; // select held high before this
    repeat (4) @(posedge clk_in); // select to first fall
    for (int i = 0; i < nb; i++) begin
      sck_out <= 1'b0;
      mosi_out <= tx[31-i]; // most significant first
      repeat (4) @(posedge clk_in);
      rx = {rx[30:0], miso_in}; // reply bit must be out by now
      repeat (ph - 4) @(posedge clk_in); // low phase
      sck_out <= 1'b1; // port takes the bit here
      repeat (ph) @(posedge clk_in); // high phase
    end
    sel_n_out <= 1'b1; // a full phase after the last rise
    mosi_out <= ~mosi_out; // released line shows no stale bit
    repeat (4) @(posedge clk_in); // select high gap
  endtask : xfer
endmodule : hsdp_host_model

// ---- tb.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
module tb;
  import hsdp_pkg::*;
  logic clk_in = 1'b0; // system clock
  logic rst_in = 1'b1; // reset, held at start
  logic sel_n; // select pin
  logic sck; // serial clock pin
  logic mosi; // request data pin
  logic sdo; // reply or interrupt pin
  hsdp_req_t req; // decoded request
  hsdp_wb_req_t wb = '0; // bus request
  logic ack; // bus ack
  logic [31:0] rdat; // bus read data
  int n_fail = 0; // mismatches
  int tests_run = 0; // comparisons
  int n_valid = 0; // request pulses seen
  int cyc_cnt = 0; // timeout counter
  logic [31:0] rx; // reply of the last frame
  // frame cases: request, phase, mask, decoded result, reply
  logic [31:0] c_tx [4] = '{32'h1A000123, 32'hFFABCDEF, 32'h02ABCDEF, 32'h7E5A5A5A};
  int c_ph [4] = '{8, 8, 40, 8};
  logic [31:0] c_mk [4] = '{32'hFFFFFF, 32'hFFFFFF, 32'h0000FF, 32'hFFFFFF};
  logic [31:0] c_ex [4] = '{32'h1A000123, 32'hFF000000, 32'h020000EF, 32'h7E5A5A5A};
  logic [31:0] c_rp [4] = '{32'hA5123456, 32'h0FFEDCBA, 32'hC3000001, 32'h3C0F0F0F};
  // reset value table, last entry unmapped
  logic [7:0] r_a [7] = '{REG_CTRL, REG_STATUS, REG_RDATA, REG_REQ, REG_EVT, REG_WMASK, 8'h20};
  logic [31:0] r_v [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFFFF, 32'h0};

  always #5 clk_in = ~clk_in;

  hsdp_host_model host (.clk_in(clk_in), .miso_in(sdo), .sel_n_out(sel_n),
                        .sck_out(sck), .mosi_out(mosi));
  hsdp_port uut (.clk_in(clk_in), .rst_in(rst_in), .host_select_n_in(sel_n),
                 .host_serial_clock_in(sck), .host_serial_in_in(mosi),
                 .host_serial_out_out(sdo), .req_out(req), .wb_in(wb),
                 .wb_ack_out(ack), .wb_dat_out(rdat));

  ////////////////////////////////////////////////////////////////
  // pulse counter and hang guard; frames take some 520 cycles, the slow one 2568
  always @(posedge clk_in) begin
    cyc_cnt <= cyc_cnt + 1;
    if (req.valid === 1'b1) n_valid <= n_valid + 1;
    if (cyc_cnt == 30000) begin
      n_fail = n_fail + 1; // a hang counts as a mismatch
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // classic single cycle, held until ack is sampled
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          output logic [31:0] q);
    int n;
    n = 0;
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    check("bus ack", {31'h0, ack}, 32'h1);
    wb <= '0;
    @(posedge clk_in); // bus idle for one cycle
  endtask : wb_cycle

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] q;
    wb_cycle(1'b1, adr, dat, q);
  endtask : wr

  task automatic rd(input string what, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(1'b0, adr, 32'h0, q);
    check(what, q, exp);
  endtask : rd

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    // reset values, unmapped place included
    check("idle sdo", {31'h0, sdo}, 32'h1);
    for (int i = 0; i < 7; i++) rd("reset value", r_a[i], r_v[i]);
    $display("test reset values done");
    // idle output follows the interrupt level, inverted
    wr(REG_CTRL, 32'h1);
    repeat (2) @(posedge clk_in);
    check("idle sdo int", {31'h0, sdo}, 32'h0);
    $display("test idle interrupt done");
    // good frames: reply, decode, masking, slow clock
    for (int i = 0; i < 4; i++) begin
      wr(REG_STATUS, {24'h0, c_rp[i][31:24]});
      wr(REG_RDATA, {8'h0, c_rp[i][23:0]});
      wr(REG_WMASK, c_mk[i]);
      host.xfer(32, c_tx[i], c_ph[i], rx);
      check("sdo after frame", {31'h0, sdo}, 32'h0);
      check("reply", rx, c_rp[i]);
      repeat (4) @(posedge clk_in);
      check("request pulses", n_valid, i + 1);
      check("decoded request", req[31:0], c_ex[i]);
      rd("last request", REG_REQ, c_ex[i]);
      rd("good event", REG_EVT, 32'h1);
      wr(REG_EVT, 32'h1);
      $display("test frame %0d done", i);
    end
    // short frame is thrown away
    wr(REG_CTRL, 32'h0);
    repeat (2) @(posedge clk_in);
    check("idle sdo clear", {31'h0, sdo}, 32'h1);
    fork
      host.xfer(31, 32'h1A000123, 8, rx);
      begin
        repeat (20) @(posedge clk_in);
        rd("busy event", REG_EVT, 32'h4);
      end
    join
    check("sdo after short", {31'h0, sdo}, 32'h1);
    repeat (4) @(posedge clk_in);
    check("no pulse on short", n_valid, 4);
    rd("count event", REG_EVT, 32'h2);
    wr(REG_EVT, 32'h2);
    rd("event cleared", REG_EVT, 32'h0);
    $display("test short frame done");
    report_and_stop();
  end
endmodule : tb
